// >>> fhr_host_model.sv
// Purpose: host processor side of the register bus
// Assumes: one access per call, strobe held one cycle
// Notes: released address and data lines show inverted values
`default_nettype none
module fhr_host_model
  import fhr_pkg::*;
(
  input wire logic core_clk_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] data_o,
  output logic rd_o,
  output logic wr_o,
  output logic dma_ack_o
);
  initial begin
    addr_o = 16'h0000;
    data_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    dma_ack_o = 1'b0;
  end
  // programmed or dma cycle, base set by caller first
  task automatic xfer(input logic r, input logic w, input logic d, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] v);
    @(posedge core_clk_i);
    #5;
    addr_o = a;
    data_o = v;
    rd_o = r;
    wr_o = w;
    dma_ack_o = d;
    @(posedge core_clk_i);
    #5;
    rd_o = 1'b0;
    wr_o = 1'b0;
    dma_ack_o = 1'b0;
    addr_o = ~a;
    data_o = ~v;
  endtask
endmodule
`default_nettype wire

// >>> fhr_mode.sv
// Purpose: personality and floppy mode selection from configuration bits
// Assumes: configuration bits held in the configuration block
// Notes: pure decode, no state
`default_nettype none
module fhr_mode
  import fhr_pkg::*;
(
  input wire logic ident_bit_i,
  input wire logic recording_select_bit_i,
  input wire logic enh_floppy_bit_i,
  output fhr_pers_t pers_o,
  output logic enhanced_o,
  output logic dmaen_valid_o,
  output logic always_driven_o,
  output logic tc_active_high_o,
  output logic density_active_high_o
);
  always_comb begin
    if (ident_bit_i && recording_select_bit_i) begin
      pers_o = PERS_FIRST;
    end else if (!ident_bit_i && recording_select_bit_i) begin
      pers_o = PERS_SECOND;
    end else begin
      pers_o = PERS_THIRD;
    end
  end
  assign enhanced_o = enh_floppy_bit_i;
  assign dmaen_valid_o = (pers_o != PERS_SECOND);
  assign always_driven_o = (pers_o == PERS_SECOND);
  assign tc_active_high_o = (pers_o != PERS_SECOND);
  assign density_active_high_o = (pers_o == PERS_FIRST);
endmodule
`default_nettype wire

// >>> fhr_pkg.sv
// Purpose: shared constants and types for the floppy host register front end
// Assumes: 8-bit host data, 3-bit register offset within the floppy block
// Notes: offsets are relative to the programmed base address
`default_nettype none
package fhr_pkg;
  localparam int DATA_W = 8;
  localparam int OFS_W = 3;
  localparam int ADDR_W = 16;
  localparam logic [OFS_W-1:0] OFS_STATUS_A = 3'h0;
  localparam logic [OFS_W-1:0] OFS_STATUS_B = 3'h1;
  localparam logic [OFS_W-1:0] OFS_DIG_OUT = 3'h2;
  localparam logic [OFS_W-1:0] OFS_TAPE = 3'h3;
  localparam logic [OFS_W-1:0] OFS_MAIN_RATE = 3'h4;
  localparam logic [OFS_W-1:0] OFS_DATA_FIFO = 3'h5;
  localparam logic [OFS_W-1:0] OFS_RESERVED = 3'h6;
  localparam logic [OFS_W-1:0] OFS_DIN_CFG = 3'h7;
  localparam logic [ADDR_W-1:0] CFG_PORT_LOW = 16'h03F0;
  localparam logic [ADDR_W-1:0] CFG_PORT_HIGH = 16'h0370;
  localparam logic [ADDR_W-1:0] BASE_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DIG_OUT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] TAPE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RATE_RESET = 8'h02;
  localparam logic [DATA_W-1:0] CFG_CTRL_RESET = 8'h02;
  localparam logic [DATA_W-1:0] RSVD_READ = 8'hFF;
  localparam logic [DATA_W-1:0] TAPE_NORMAL_MASK = 8'h03;
  localparam int DOR_DMAEN_BIT = 3;
  localparam int DOR_NRESET_BIT = 2;
  localparam int SA_DIR_BIT = 0;
  localparam int SA_WP_BIT = 1;
  localparam int SA_IDX_BIT = 2;
  localparam int SA_HEAD_BIT = 3;
  localparam int SA_TRK_BIT = 4;
  localparam int SA_STEP_BIT = 5;
  localparam int SA_B6_BIT = 6;
  localparam int SA_INT_BIT = 7;

  typedef enum logic [2:0] {
    PERS_FIRST  = 3'b001,
    PERS_SECOND = 3'b010,
    PERS_THIRD  = 3'b100
  } fhr_pers_t;

  typedef struct packed {
    logic head_dir_in;
    logic head_side;
    logic step_out;
    logic dma_request;
    logic floppy_interrupt_out;
  } fhr_core_t;

  typedef struct packed {
    logic write_protect_low;
    logic index_low;
    logic track_zero_low;
    logic second_drive_present_low;
  } fhr_drive_t;
endpackage
`default_nettype wire

// >>> fhr_sync.sv
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: inputs asynchronous to core_clk_i
// Notes: first stage read only by second stage
`default_nettype none
module fhr_sync #(
  parameter int W = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
    end
  end
  assign q_o = s2_reg;
endmodule
`default_nettype wire

// >>> fhr_top.sv
// Purpose: host register front end of the floppy controller
// Assumes: host strobes already qualified and synchronous to core_clk_i
// Notes: controller core, status B content and main status come from outside
//
// Notes on behaviour
// - both personality bits high: first set, enable bit honoured, outputs may float
// - identity low, recording high: second set, enable ignored, outputs always driven
// - both bits low: third set, enable honoured, count high, density low
// - enhanced-floppy bit zero gives normal mode; mode only alters tape register
// - offsets 0..6 map status, output control, tape, main/rate, fifo, reserved
// - every host register is eight bits wide
// - transfers accepted by programmed I/O or by DMA acknowledge
// - configuration port at low or high pair, write only
// - block keeps working while configuration state is active
// - first status readable in second and third sets; bus undriven in first
// - second set bit 0 shows direction, one means inward
// - second set bit 1 shows write protect low, follows forced protect
// - second set bit 2 shows index input active low
// - second set bit 3 shows head side, one selects side 1
// - second set bit 4 shows track zero active low
// - second set bit 5 shows step output active high
// - second set bit 6 shows second drive present, active low
// - bit 7 shows floppy interrupt output state
// - third set layout: int, request, latched step, track, nhead, index, wp, head_direction_inverted
// - latched step set by step going active, cleared by digital input read or reset
// - third set bit 0 direction low means inward; bit 3 inverted side
`default_nettype none
module fhr_top
  import fhr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic dma_ack_i,
  input wire logic cfg_high_pair_i,
  input wire logic cfg_state_i,
  input wire logic [ADDR_W-1:0] base_addr_i,
  input wire logic block_enable_i,
  input wire logic ident_bit_i,
  input wire logic recording_select_bit_i,
  input wire logic enh_floppy_bit_i,
  input wire logic force_wp_i,
  input wire fhr_core_t core_i,
  input wire fhr_drive_t drive_i,
  input wire logic [DATA_W-1:0] status_b_i,
  input wire logic [DATA_W-1:0] main_status_i,
  input wire logic [DATA_W-1:0] fifo_rd_data_i,
  input wire logic [DATA_W-1:0] digital_input_i,
  input wire logic terminal_count_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_n_o,
  output logic cfg_wr_o,
  output logic [DATA_W-1:0] cfg_data_o,
  output logic fifo_rd_o,
  output logic fifo_wr_o,
  output logic [DATA_W-1:0] fifo_wr_data_o,
  output logic [DATA_W-1:0] digital_output_control_o,
  output logic [DATA_W-1:0] tape_drive_control_o,
  output logic [DATA_W-1:0] rate_select_o,
  output logic [DATA_W-1:0] config_control_o,
  output logic soft_reset_o,
  output logic floppy_interrupt_out_o,
  output logic floppy_interrupt_oe_n_o,
  output logic dma_request_o,
  output logic dma_request_oe_n_o,
  output logic terminal_count_o,
  output logic density_select_out_o,
  output logic enhanced_mode_o
);
  fhr_pers_t pers;
  logic enhanced;
  logic dmaen_valid;
  logic always_driven;
  logic tc_active_high;
  logic density_active_high;
  fhr_drive_t drive_s;
  logic hit;
  logic [OFS_W-1:0] ofs;
  logic rd_hit;
  logic wr_hit;
  logic dma_rd;
  logic dma_wr;
  logic step_prev_reg;
  logic step_latch_reg;
  logic [DATA_W-1:0] dig_out_reg;
  logic [DATA_W-1:0] tape_reg;
  logic [DATA_W-1:0] rate_reg;
  logic [DATA_W-1:0] cfg_ctrl_reg;
  logic [DATA_W-1:0] data_reg;
  logic data_oe_n_reg;
  logic [DATA_W-1:0] data_next;
  logic drive_next;
  logic [DATA_W-1:0] sra_second;
  logic [DATA_W-1:0] sra_third;
  logic [DATA_W-1:0] fifo_wr_data_reg;
  logic [DATA_W-1:0] cfg_data_reg;
  logic cfg_wr_reg;
  logic outputs_enabled;
  logic wp_eff_low;

  fhr_mode u_mode (
    .ident_bit_i(ident_bit_i),
    .recording_select_bit_i(recording_select_bit_i),
    .enh_floppy_bit_i(enh_floppy_bit_i),
    .pers_o(pers),
    .enhanced_o(enhanced),
    .dmaen_valid_o(dmaen_valid),
    .always_driven_o(always_driven),
    .tc_active_high_o(tc_active_high),
    .density_active_high_o(density_active_high)
  );

  fhr_sync #(
    .W($bits(fhr_drive_t))
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(drive_i),
    .rst_val_i('0),
    .q_o(drive_s)
  );

  // block decode; enabled only once the host has set it up
  assign hit = block_enable_i && (addr_i[ADDR_W-1:OFS_W] == base_addr_i[ADDR_W-1:OFS_W]);
  assign ofs = addr_i[OFS_W-1:0];
  // dma cycles reach the data fifo without an address
  assign dma_rd = dma_ack_i && rd_i && dig_out_reg[DOR_DMAEN_BIT] | (dma_ack_i && rd_i && !dmaen_valid);
  assign dma_wr = dma_ack_i && wr_i && (dig_out_reg[DOR_DMAEN_BIT] || !dmaen_valid);
  // decode runs regardless of configuration state
  assign rd_hit = rd_i && hit && !dma_ack_i;
  assign wr_hit = wr_i && hit && !dma_ack_i;

  // configuration port is write only
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_wr_reg <= 1'b0;
      cfg_data_reg <= '0;
    end else begin
      cfg_wr_reg <= wr_i && !dma_ack_i && (addr_i == (cfg_high_pair_i ? CFG_PORT_HIGH : CFG_PORT_LOW));
      if (wr_i && !dma_ack_i) begin
        cfg_data_reg <= data_i;
      end
    end
  end
  assign cfg_wr_o = cfg_wr_reg;
  assign cfg_data_o = cfg_data_reg;

  // writable floppy registers, eight bits each
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dig_out_reg <= DIG_OUT_RESET;
      tape_reg <= TAPE_RESET;
      rate_reg <= RATE_RESET;
      cfg_ctrl_reg <= CFG_CTRL_RESET;
    end else if (wr_hit) begin
      unique case (ofs)
        OFS_DIG_OUT: begin
          dig_out_reg <= data_i;
        end
        OFS_TAPE: begin
          tape_reg <= enhanced ? data_i : (data_i & TAPE_NORMAL_MASK);
        end
        OFS_MAIN_RATE: begin
          rate_reg <= data_i;
        end
        OFS_DIN_CFG: begin
          cfg_ctrl_reg <= data_i;
        end
        default: begin
        end
      endcase
    end
  end

  // fifo strobes from programmed or dma access
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_rd_o <= 1'b0;
      fifo_wr_o <= 1'b0;
      fifo_wr_data_reg <= '0;
    end else begin
      fifo_rd_o <= (rd_hit && ofs == OFS_DATA_FIFO) || dma_rd;
      fifo_wr_o <= (wr_hit && ofs == OFS_DATA_FIFO) || dma_wr;
      if ((wr_hit && ofs == OFS_DATA_FIFO) || dma_wr) begin
        fifo_wr_data_reg <= data_i;
      end
    end
  end
  assign fifo_wr_data_o = fifo_wr_data_reg;

  // latched step for the third personality
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_prev_reg <= 1'b0;
      step_latch_reg <= 1'b0;
    end else begin
      step_prev_reg <= core_i.step_out;
      if (core_i.step_out && !step_prev_reg) begin
        step_latch_reg <= 1'b1;
      end else if ((rd_hit && ofs == OFS_DIN_CFG) || !dig_out_reg[DOR_NRESET_BIT]) begin
        step_latch_reg <= 1'b0;
      end
    end
  end

  assign wp_eff_low = drive_s.write_protect_low && !force_wp_i;

  always_comb begin
    sra_second = '0;
    sra_second[SA_DIR_BIT] = core_i.head_dir_in;
    sra_second[SA_WP_BIT] = wp_eff_low;
    sra_second[SA_IDX_BIT] = drive_s.index_low;
    sra_second[SA_HEAD_BIT] = core_i.head_side;
    sra_second[SA_TRK_BIT] = drive_s.track_zero_low;
    sra_second[SA_STEP_BIT] = core_i.step_out;
    sra_second[SA_B6_BIT] = drive_s.second_drive_present_low;
    sra_second[SA_INT_BIT] = core_i.floppy_interrupt_out;
  end

  always_comb begin
    sra_third = '0;
    sra_third[SA_DIR_BIT] = !core_i.head_dir_in;
    sra_third[SA_WP_BIT] = !wp_eff_low;
    sra_third[SA_IDX_BIT] = !drive_s.index_low;
    sra_third[SA_HEAD_BIT] = !core_i.head_side;
    sra_third[SA_TRK_BIT] = !drive_s.track_zero_low;
    sra_third[SA_STEP_BIT] = step_latch_reg;
    sra_third[SA_B6_BIT] = core_i.dma_request;
    sra_third[SA_INT_BIT] = core_i.floppy_interrupt_out;
  end

  // read data mux; status reads float in the first personality
  always_comb begin
    data_next = data_reg;
    drive_next = 1'b0;
    if (dma_rd) begin
      data_next = fifo_rd_data_i;
      drive_next = 1'b1;
    end else if (rd_hit) begin
      drive_next = 1'b1;
      unique case (ofs)
        OFS_STATUS_A: begin
          data_next = (pers == PERS_SECOND) ? sra_second : sra_third;
          drive_next = (pers != PERS_FIRST);
        end
        OFS_STATUS_B: begin
          data_next = status_b_i;
          drive_next = (pers != PERS_FIRST);
        end
        OFS_DIG_OUT: begin
          data_next = dig_out_reg;
        end
        OFS_TAPE: begin
          data_next = tape_reg;
        end
        OFS_MAIN_RATE: begin
          data_next = main_status_i;
        end
        OFS_DATA_FIFO: begin
          data_next = fifo_rd_data_i;
        end
        OFS_RESERVED: begin
          data_next = RSVD_READ;
        end
        OFS_DIN_CFG: begin
          data_next = digital_input_i;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_reg <= '0;
      data_oe_n_reg <= 1'b1;
    end else begin
      data_reg <= data_next;
      data_oe_n_reg <= !drive_next;
    end
  end
  assign data_o = data_reg;
  assign data_oe_n_o = data_oe_n_reg;

  // pin personalities
  assign outputs_enabled = always_driven || dig_out_reg[DOR_DMAEN_BIT];
  assign floppy_interrupt_out_o = core_i.floppy_interrupt_out;
  assign floppy_interrupt_oe_n_o = !outputs_enabled;
  assign dma_request_o = core_i.dma_request;
  assign dma_request_oe_n_o = !outputs_enabled;
  assign terminal_count_o = tc_active_high ? terminal_count_i : !terminal_count_i;
  assign density_select_out_o = density_active_high ? rate_reg[0] : !rate_reg[0];
  assign soft_reset_o = !dig_out_reg[DOR_NRESET_BIT];
  assign enhanced_mode_o = enhanced;
  assign digital_output_control_o = dig_out_reg;
  assign tape_drive_control_o = tape_reg;
  assign rate_select_o = rate_reg;
  assign config_control_o = cfg_ctrl_reg;
endmodule
`default_nettype wire

// >>> fhr_top_assertions.sv
// Purpose: port-level checks on the floppy host register front end
// Assumes: sees fhr_top ports only
// Notes: bound below the module
`default_nettype none
module fhr_top_assertions
  import fhr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic dma_ack_i,
  input wire logic cfg_high_pair_i,
  input wire logic [ADDR_W-1:0] base_addr_i,
  input wire logic block_enable_i,
  input wire logic ident_bit_i,
  input wire logic recording_select_bit_i,
  input wire logic enh_floppy_bit_i,
  input wire fhr_core_t core_i,
  input wire logic terminal_count_i,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic data_oe_n_o,
  input wire logic cfg_wr_o,
  input wire logic [DATA_W-1:0] cfg_data_o,
  input wire logic fifo_rd_o,
  input wire logic [DATA_W-1:0] digital_output_control_o,
  input wire logic floppy_interrupt_out_o,
  input wire logic floppy_interrupt_oe_n_o,
  input wire logic dma_request_oe_n_o,
  input wire logic terminal_count_o,
  input wire logic enhanced_mode_o
);
  logic hit;
  logic pers1;
  logic pers2;
  assign hit = block_enable_i && !dma_ack_i && (addr_i[15:3] == base_addr_i[15:3]);
  assign pers1 = ident_bit_i && recording_select_bit_i;
  assign pers2 = !ident_bit_i && recording_select_bit_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence sra_read;
    rd_i && hit && addr_i[2:0] == OFS_STATUS_A;
  endsequence
  sequence cfg_write;
    wr_i && !dma_ack_i && addr_i == (cfg_high_pair_i ? CFG_PORT_HIGH : CFG_PORT_LOW);
  endsequence
  chk_sra_float: assert property (sra_read ##0 pers1 |=> data_oe_n_o)
    else $error("status read drove bus in first set");
  chk_sra_driven: assert property (sra_read ##0 !pers1 |=> !data_oe_n_o)
    else $error("status read not driven");
  chk_rsvd_value: assert property (rd_i && hit && addr_i[2:0] == OFS_RESERVED |=> data_o == RSVD_READ)
    else $error("reserved read value wrong");
  chk_dor_load: assert property (wr_i && hit && addr_i[2:0] == OFS_DIG_OUT |=>
    digital_output_control_o == $past(data_i))
    else $error("output control not loaded");
  chk_cfg_pulse: assert property (cfg_write |=> cfg_wr_o && cfg_data_o == $past(data_i))
    else $error("config write missed");
  chk_cfg_wo: assert property (rd_i && !wr_i |=> !cfg_wr_o)
    else $error("config write on a read");
  chk_tc_polarity: assert property (terminal_count_o == (pers2 ? !terminal_count_i : terminal_count_i))
    else $error("terminal count polarity wrong");
  chk_ps2_driven: assert property (pers2 |-> !floppy_interrupt_oe_n_o && !dma_request_oe_n_o)
    else $error("outputs not driven in second set");
  chk_int_state: assert property (floppy_interrupt_out_o == core_i.floppy_interrupt_out)
    else $error("interrupt output mismatch");
  chk_dma_fifo: assert property (dma_ack_i && rd_i && (pers2 || digital_output_control_o[DOR_DMAEN_BIT])
    |=> fifo_rd_o)
    else $error("dma read missed");
  chk_enh_mode: assert property (enhanced_mode_o == enh_floppy_bit_i)
    else $error("floppy mode wrong");
endmodule
bind fhr_top fhr_top_assertions i_fhr_top_assertions (.*);
`default_nettype wire

// >>> floppy_host_register_interface_tb.sv
// Purpose: self-checking bench for the floppy host register front end
// Assumes: answers land one cycle after the strobe edge
// Notes: base at 0x0100, configuration state held active
`default_nettype none
module floppy_host_register_interface_tb
  import fhr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i, rst_i, rd_i, wr_i, dma_ack_i, cfg_high_pair_i, cfg_state_i, block_enable_i;
  logic ident_bit_i, recording_select_bit_i, enh_floppy_bit_i, force_wp_i, terminal_count_i;
  logic [ADDR_W-1:0] addr_i, base_addr_i;
  logic [DATA_W-1:0] data_i, status_b_i, main_status_i, fifo_rd_data_i, digital_input_i, data_o, cfg_data_o;
  logic [DATA_W-1:0] fifo_wr_data_o, digital_output_control_o, tape_drive_control_o, rate_select_o, config_control_o;
  logic data_oe_n_o, cfg_wr_o, fifo_rd_o, fifo_wr_o, soft_reset_o, floppy_interrupt_out_o, floppy_interrupt_oe_n_o;
  logic dma_request_o, dma_request_oe_n_o, terminal_count_o, density_select_out_o, enhanced_mode_o;
  fhr_core_t core_i;
  fhr_drive_t drive_i;
  int errors, n_compared;
  fhr_top i_fhr_top (.*);
  fhr_host_model i_fhr_host_model (.core_clk_i(core_clk_i), .addr_o(addr_i), .data_o(data_i), .rd_o(rd_i),
    .wr_o(wr_i), .dma_ack_o(dma_ack_i));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [2:0] o);
    i_fhr_host_model.xfer(1'b1, 1'b0, 1'b0, {base_addr_i[15:3], o}, 8'h00);
  endtask
  task automatic wr(input logic [2:0] o, input logic [7:0] v);
    i_fhr_host_model.xfer(1'b0, 1'b1, 1'b0, {base_addr_i[15:3], o}, v);
  endtask
  task automatic set_pers(input int p);
    ident_bit_i = (p == 0);
    recording_select_bit_i = (p != 2);
  endtask
  task automatic t_reset();
    chk("dor", DIG_OUT_RESET, digital_output_control_o);
    chk("rate", RATE_RESET, rate_select_o);
    chk("ccr", CFG_CTRL_RESET, config_control_o);
    chk("oe", 8'h01, {7'h00, data_oe_n_o});
  endtask
  task automatic t_map();
    set_pers(1);
    wr(OFS_DIG_OUT, 8'h0C);
    chk("soft", 8'h00, {7'h00, soft_reset_o});
    rd(OFS_DIG_OUT);
    chk("dor rd", 8'h0C, data_o);
    enh_floppy_bit_i = 1'b0;
    wr(OFS_TAPE, 8'hFF);
    chk("tape", 8'h03, tape_drive_control_o);
    wr(OFS_MAIN_RATE, 8'h01);
    chk("rate", 8'h01, rate_select_o);
    rd(OFS_MAIN_RATE);
    chk("msr", 8'h81, data_o);
    rd(OFS_DATA_FIFO);
    chk("fifo", 8'h3C, data_o);
    chk("fifo rd", 8'h01, {7'h00, fifo_rd_o});
    rd(OFS_RESERVED);
    chk("rsvd", 8'hFF, data_o);
    wr(OFS_DIN_CFG, 8'h03);
    chk("ccr", 8'h03, config_control_o);
    rd(OFS_DIN_CFG);
    chk("din", 8'hA5, data_o);
    rd(OFS_STATUS_B);
    chk("srb", 8'h5A, data_o);
    block_enable_i = 1'b0;
    rd(OFS_STATUS_B);
    chk("unhit", 8'h01, {7'h00, data_oe_n_o});
    block_enable_i = 1'b1;
  endtask
  task automatic t_sra();
    set_pers(0);
    rd(OFS_STATUS_A);
    chk("sra oe", 8'h01, {7'h00, data_oe_n_o});
    set_pers(1);
    rd(OFS_STATUS_A);
    chk("sra 2", 8'h93, data_o);
    force_wp_i = 1'b1;
    rd(OFS_STATUS_A);
    chk("sra wp", 8'h91, data_o);
    force_wp_i = 1'b0;
    set_pers(2);
    rd(OFS_STATUS_A);
    chk("sra 3", 8'hCC, data_o);
  endtask
  task automatic t_step();
    wr(OFS_DIG_OUT, 8'h04);
    core_i.step_out = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #5;
    core_i.step_out = 1'b0;
    rd(OFS_STATUS_A);
    chk("step set", 8'h20, data_o & 8'h20);
    rd(OFS_DIN_CFG);
    rd(OFS_STATUS_A);
    chk("step clr", 8'h00, data_o & 8'h20);
  endtask
  task automatic t_cfg();
    i_fhr_host_model.xfer(1'b0, 1'b1, 1'b0, CFG_PORT_LOW, 8'h55);
    chk("cfg lo", 8'h55, cfg_wr_o ? cfg_data_o : 8'h00);
    i_fhr_host_model.xfer(1'b1, 1'b0, 1'b0, CFG_PORT_LOW, 8'h00);
    chk("cfg rd", 8'h00, {7'h00, cfg_wr_o});
    cfg_high_pair_i = 1'b1;
    i_fhr_host_model.xfer(1'b0, 1'b1, 1'b0, CFG_PORT_HIGH, 8'hAA);
    chk("cfg hi", 8'hAA, cfg_wr_o ? cfg_data_o : 8'h00);
  endtask
  task automatic t_dma();
    set_pers(0);
    wr(OFS_DIG_OUT, 8'h04);
    chk("int float", 8'h01, {7'h00, floppy_interrupt_oe_n_o});
    i_fhr_host_model.xfer(1'b1, 1'b0, 1'b1, 16'h0000, 8'h00);
    chk("dma off", 8'h00, {7'h00, fifo_rd_o});
    set_pers(1);
    i_fhr_host_model.xfer(1'b1, 1'b0, 1'b1, 16'h0000, 8'h00);
    chk("dma ps2", 8'h01, {7'h00, fifo_rd_o});
    set_pers(2);
    wr(OFS_DIG_OUT, 8'h0C);
    i_fhr_host_model.xfer(1'b0, 1'b1, 1'b1, 16'h0000, 8'h96);
    chk("dma wr", 8'h96, fifo_wr_o ? fifo_wr_data_o : 8'h00);
  endtask
  task automatic t_pins();
    for (int p = 0; p < 3; p++) begin
      set_pers(p);
      #1;
      chk("tc", (p == 1) ? 8'h00 : 8'h01, {7'h00, terminal_count_o});
      chk("dens", (p == 0) ? 8'h01 : 8'h00, {7'h00, density_select_out_o});
      chk("drq", 8'h01, {7'h00, dma_request_o});
    end
  endtask
  initial begin
    rst_i = 1'b1;
    cfg_high_pair_i = 1'b0;
    cfg_state_i = 1'b1;
    base_addr_i = 16'h0100;
    block_enable_i = 1'b1;
    enh_floppy_bit_i = 1'b1;
    force_wp_i = 1'b0;
    terminal_count_i = 1'b1;
    core_i = 5'b10011;
    drive_i = 4'b1010;
    status_b_i = 8'h5A;
    main_status_i = 8'h81;
    fifo_rd_data_i = 8'h3C;
    digital_input_i = 8'hA5;
    set_pers(1);
    repeat (6) @(posedge core_clk_i);
    #5;
    rst_i = 1'b0;
    t_reset();
    t_map();
    t_sra();
    t_step();
    t_cfg();
    t_dma();
    t_pins();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge core_clk_i);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
